// ---- rtl/gio_defines.vh ----
// Register offsets, field positions and reset values of the general purpose I/O port.
`ifndef GIO_DEFINES_VH
`define GIO_DEFINES_VH
// ****************************************
// Register addresses
// ****************************************
`define GIO_ADDR_PIN_LEVEL_READBACK 32'h80000900
`define GIO_ADDR_PIN_DRIVE_VALUE 32'h80000904
`define GIO_ADDR_PIN_DIRECTION 32'h80000908
`define GIO_ADDR_IRQ_LINE_MASK 32'h8000090C
`define GIO_ADDR_IRQ_LINE_POLARITY 32'h80000910
`define GIO_ADDR_IRQ_LINE_EDGE_SELECT 32'h80000914
// ****************************************
// Field layout and reset values
// ****************************************
`define GIO_FIELD_MSB 15
`define GIO_IRQ_FIELD_LSB 1
`define GIO_IRQ_WRITE_MASK 16'hFFFE
`define GIO_RESET_VALUE 16'h0000
`endif

// ---- rtl/gio_sync2.v ----
// Two flip-flop synchroniser for a bus of input lines.
`timescale 1ns/100ps
module gio_sync2 #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always @(posedge sys_clk) begin
        if (reset) begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- rtl/gio_port.v ----
// Sixteen-line general purpose I/O port with per-line interrupts.
// How it works
// - Sixteen lines, each independently input or output; lines 1..15 may interrupt.
// - Each line is a pad whose driver software enables per line.
// - Every pad input passes two flip-flops before any use.
// - Readback register returns synchronised levels in bits 15..0; writes ignored.
// - Direction bit one enables the driver; zero leaves the line input.
// - An output line drives its bit of the drive value register.
// - Lines 1..15 each drive own interrupt output; line 0 none.
// - An interrupt is signalled only while its mask bit is one.
// - Mask and polarity hold bits 15..1; bit 0 reserved.
// - Edge select zero means level sensitive, one means edge triggered.
// - Polarity: level low/high, or falling/rising edge in edge mode.
// - All control registers reset to zero: inputs, interrupts disabled.
`timescale 1ns/100ps
`include "gio_defines.vh"
module gio_port #(
    parameter NLINES = 16
) (
    input wire sys_clk,
    input wire reset,
    input wire reg_sel,
    input wire reg_write,
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire [NLINES-1:0] io_line_in,
    output reg [NLINES-1:0] io_line_out,
    output reg [NLINES-1:0] io_line_oe,
    output reg [NLINES-1:0] irq_out
);
    // ****************************************
    // Control registers
    // ****************************************
    reg [NLINES-1:0] pin_drive_value_q;
    reg [NLINES-1:0] pin_direction_q;
    reg [NLINES-1:0] irq_line_mask_q;
    reg [NLINES-1:0] irq_line_polarity_q;
    reg [NLINES-1:0] irq_line_edge_select_q;
    reg [NLINES-1:0] level_prev_q;
    wire [NLINES-1:0] pin_level_field;
    wire [NLINES-1:0] rise_w;
    wire [NLINES-1:0] fall_w;
    wire wr_strobe_w;
    wire sel_readback_w;
    wire sel_drive_w;
    wire sel_direction_w;
    wire sel_mask_w;
    wire sel_polarity_w;
    wire sel_edge_w;
    reg [NLINES-1:0] level_match;
    reg [NLINES-1:0] edge_match;
    reg [NLINES-1:0] irq_d;
    reg [31:0] rdata_d;
    integer i;

    // ****************************************
    // Helper functions
    // ****************************************
    // Return one when the bus address matches a register.
    function hit;
        input [31:0] a;
        input [31:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Widen a line vector to a bus word whose unused upper bits read zero.
    function [31:0] to_word;
        input [NLINES-1:0] v;
        begin
            to_word = 32'h00000000;
            to_word[NLINES-1:0] = v;
        end
    endfunction

    // Keep only the interrupt fields of a written word; line 0 never interrupts.
    function [NLINES-1:0] field_mask;
        input [NLINES-1:0] v;
        integer k;
        begin
            field_mask = {NLINES{1'b0}};
            for (k = `GIO_IRQ_FIELD_LSB; k <= `GIO_FIELD_MSB; k = k + 1) begin
                if (k < NLINES) begin
                    field_mask[k] = v[k];
                end
            end
        end
    endfunction

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Every pad reaches the rest of the block only through this two-stage chain.
    gio_sync2 #(
        .WIDTH(NLINES)
    ) gio_sync2_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(io_line_in),
        .sync_out(pin_level_field)
    );

    // ****************************************
    // Address decode
    // ****************************************
    // Each select is a full address compare, so no alias of a register ever responds.
    assign wr_strobe_w = reg_sel & reg_write;
    assign sel_readback_w = hit(reg_addr, `GIO_ADDR_PIN_LEVEL_READBACK);
    assign sel_drive_w = hit(reg_addr, `GIO_ADDR_PIN_DRIVE_VALUE);
    assign sel_direction_w = hit(reg_addr, `GIO_ADDR_PIN_DIRECTION);
    assign sel_mask_w = hit(reg_addr, `GIO_ADDR_IRQ_LINE_MASK);
    assign sel_polarity_w = hit(reg_addr, `GIO_ADDR_IRQ_LINE_POLARITY);
    assign sel_edge_w = hit(reg_addr, `GIO_ADDR_IRQ_LINE_EDGE_SELECT);

    // ****************************************
    // Register writes
    // ****************************************
    // The readback register has no write path, so a store to its address is lost.
    always @(posedge sys_clk) begin
        if (reset) begin
            pin_drive_value_q <= `GIO_RESET_VALUE;
        end else if (wr_strobe_w && sel_drive_w) begin
            pin_drive_value_q <= reg_wdata[NLINES-1:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            pin_direction_q <= `GIO_RESET_VALUE;
        end else if (wr_strobe_w && sel_direction_w) begin
            pin_direction_q <= reg_wdata[NLINES-1:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            irq_line_mask_q <= `GIO_RESET_VALUE;
        end else if (wr_strobe_w && sel_mask_w) begin
            irq_line_mask_q <= field_mask(reg_wdata[NLINES-1:0]);
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            irq_line_polarity_q <= `GIO_RESET_VALUE;
        end else if (wr_strobe_w && sel_polarity_w) begin
            irq_line_polarity_q <= field_mask(reg_wdata[NLINES-1:0]);
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            irq_line_edge_select_q <= `GIO_RESET_VALUE;
        end else if (wr_strobe_w && sel_edge_w) begin
            irq_line_edge_select_q <= field_mask(reg_wdata[NLINES-1:0]);
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    // Reads are registered, so data appears one cycle after the address.
    always @* begin
        rdata_d = 32'h00000000;
        if (sel_readback_w) begin
            rdata_d = to_word(pin_level_field);
        end else if (sel_drive_w) begin
            rdata_d = to_word(pin_drive_value_q);
        end else if (sel_direction_w) begin
            rdata_d = to_word(pin_direction_q);
        end else if (sel_mask_w) begin
            rdata_d = to_word(irq_line_mask_q);
        end else if (sel_polarity_w) begin
            rdata_d = to_word(irq_line_polarity_q);
        end else if (sel_edge_w) begin
            rdata_d = to_word(irq_line_edge_select_q);
        end
    end

    // ****************************************
    // Interrupt detection
    // ****************************************
    // Only the synchronised level is used, so a glitch shorter than a clock fires only if it spans a clock edge.
    assign rise_w = pin_level_field & ~level_prev_q;
    assign fall_w = ~pin_level_field & level_prev_q;

    always @* begin
        level_match = {NLINES{1'b0}};
        edge_match = {NLINES{1'b0}};
        irq_d = {NLINES{1'b0}};
        for (i = 1; i < NLINES; i = i + 1) begin
            level_match[i] = ~(pin_level_field[i] ^ irq_line_polarity_q[i]);
            edge_match[i] = irq_line_polarity_q[i] ? rise_w[i] : fall_w[i];
            if (irq_line_edge_select_q[i]) begin
                irq_d[i] = edge_match[i] & irq_line_mask_q[i];
            end else begin
                irq_d[i] = level_match[i] & irq_line_mask_q[i];
            end
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // Pad controls come from flip-flops, so a register write never glitches a pin.
    always @(posedge sys_clk) begin
        if (reset) begin
            io_line_out <= `GIO_RESET_VALUE;
            io_line_oe <= `GIO_RESET_VALUE;
        end else begin
            io_line_out <= pin_drive_value_q;
            io_line_oe <= pin_direction_q;
        end
    end

    // The previous level resets to the synchroniser's reset value, so no edge is invented.
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_out <= {NLINES{1'b0}};
            level_prev_q <= {NLINES{1'b0}};
        end else begin
            irq_out <= irq_d;
            level_prev_q <= pin_level_field;
        end
    end
endmodule

// ---- verif/gio_pad_model.sv ----
// Peripheral side of the sixteen pads.
`timescale 1ns/100ps
module gio_pad_model (
    input wire logic [15:0] line_out,
    input wire logic [15:0] line_oe,
    input wire logic [15:0] ext,
    output wire logic [15:0] pad
);
    // The peripheral yields each line whose port driver is on.
    assign pad = (line_oe & line_out) | (~line_oe & ext);
endmodule

// ---- verif/gio_port_assertions.sv ----
// Checker on the I/O port's pins and register reads.
`timescale 1ns/100ps
module gio_port_assertions #(
    parameter NLINES = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [NLINES-1:0] io_line_in,
    input wire logic [NLINES-1:0] io_line_out,
    input wire logic [NLINES-1:0] io_line_oe,
    input wire logic [NLINES-1:0] irq_out
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic [NLINES-1:0] mask_q;
    logic [NLINES-1:0] edge_q;
    wire wr = reg_sel && reg_write;
    // Shadow copies let the mask and edge checks see the programmed mode.
    always @(posedge sys_clk) begin
        if (reset) begin
            mask_q <= '0;
            edge_q <= '0;
        end else if (wr && reg_addr == 32'h8000090C) mask_q <= reg_wdata[NLINES-1:0];
        else if (wr && reg_addr == 32'h80000914) edge_q <= reg_wdata[NLINES-1:0];
    end
    a_line0_quiet: assert property (irq_out[0] == 1'b0) else $error("line 0 irq");
    a_dir_drives: assert property (wr && reg_addr == 32'h80000908 |=> ##1
        io_line_oe == $past(reg_wdata[NLINES-1:0], 2)) else $error("bad oe");
    a_out_value: assert property (wr && reg_addr == 32'h80000904 |=> ##1
        io_line_out == $past(reg_wdata[NLINES-1:0], 2)) else $error("bad out");
    a_mask_gates: assert property ((irq_out & ~$past(mask_q)) == '0) else $error("unmasked irq");
    a_edge_pulse: assert property ((irq_out & $past(irq_out) & $past(edge_q) & $past(edge_q, 2)) == '0)
        else $error("long pulse");
    a_reset_zero: assert property ($fell(reset) |-> (io_line_oe | io_line_out | irq_out) == '0)
        else $error("reset value");
    a_bit0_reserved: assert property (reg_addr == 32'h8000090C || reg_addr == 32'h80000910 |=>
        reg_rdata[0] == 1'b0) else $error("bit 0 set");
    a_upper_zero: assert property (reg_rdata[31:16] == 16'h0000) else $error("upper bits");
    a_unmapped_zero: assert property (reg_addr > 32'h80000914 |=> reg_rdata == 32'h0) else $error("unmapped");
    a_sync_read: assert property (($stable(io_line_in))[*4] ##0 reg_addr == 32'h80000900 |=>
        reg_rdata[NLINES-1:0] == $past(io_line_in)) else $error("bad readback");
    c_irq: cover property (irq_out[1]);
    c_drive: cover property (io_line_oe != '0);
    c_read: cover property (reg_rdata != 32'h0);
endmodule
bind gio_port gio_port_assertions #(.NLINES(NLINES)) gio_port_assertions_inst (.sys_clk(sys_clk), .reset(reset),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .io_line_in(io_line_in), .io_line_out(io_line_out), .io_line_oe(io_line_oe), .irq_out(irq_out));

// ---- verif/gio_port_test.sv ----
// Self-checking testbench of the I/O port.
`timescale 1ns/100ps
module gio_port_test;
    logic sys_clk = 0, reset = 1, reg_sel = 0, reg_write = 0;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [15:0] io_line_in, io_line_out, io_line_oe, irq_out, ext = 0;
    int n_fail = 0, n_checks = 0, i;
    gio_port gio_port_inst (.sys_clk(sys_clk), .reset(reset), .reg_sel(reg_sel), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .io_line_in(io_line_in),
        .io_line_out(io_line_out), .io_line_oe(io_line_oe), .irq_out(irq_out));
    gio_pad_model gio_pad_model_inst (.line_out(io_line_out), .line_oe(io_line_oe), .ext(ext), .pad(io_line_in));
    initial forever #20 sys_clk = ~sys_clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs always move 1 ns after an edge so the design samples them cleanly.
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // The strobe stays up after a write so back-to-back writes never toggle it in one step.
    task wr(input logic [31:0] a, input logic [31:0] d);
        reg_sel = 1'b1;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
    endtask
    task idle(input int n);
        reg_sel = 1'b0;
        reg_write = 1'b0;
        tick(n);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp);
        reg_sel = 1'b0;
        reg_write = 1'b0;
        reg_addr = a;
        tick(1);
        chk(reg_rdata, exp);
    endtask
    task summarize;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        begin : scenarios
            tick(10);
            reset = 1'b0;
            for (i = 0; i < 6; i++) rd(32'h80000900 + 4 * i, 32'h0);
            for (i = 0; i < 6; i++) wr(32'h80000900 + 4 * i, 32'hFFFFFFFF);
            for (i = 1; i < 6; i++) rd(32'h80000900 + 4 * i, i < 3 ? 32'hFFFF : 32'hFFFE);
            rd(32'h80000900, 32'hFFFF);
            rd(32'h80000918, 32'h0);
            $display("test registers done");
            wr(32'h80000908, 32'h00FF);
            wr(32'h80000904, 32'h1234);
            ext = 16'hA5C3;
            idle(4);
            chk({16'h0, io_line_oe}, 32'h00FF);
            chk({16'h0, io_line_out}, 32'h1234);
            rd(32'h80000900, 32'hA534);
            $display("test pads done");
            wr(32'h80000908, 32'h0);
            wr(32'h80000910, 32'h0002);
            wr(32'h80000914, 32'h0004);
            ext = 16'h0006;
            idle(5);
            chk({16'h0, irq_out}, 32'hFFFA);
            ext = 16'h0002;
            for (i = 0; i < 8 && irq_out[2] !== 1'b1; i++) idle(1);
            chk({16'h0, irq_out}, 32'hFFFE);
            if (irq_out[2] !== 1'b1) disable scenarios;
            idle(1);
            chk({16'h0, irq_out}, 32'hFFFA);
            wr(32'h80000910, 32'h0006);
            ext = 16'h0006;
            for (i = 0; i < 8 && irq_out[2] !== 1'b1; i++) idle(1);
            chk({16'h0, irq_out}, 32'hFFFE);
            if (irq_out[2] !== 1'b1) disable scenarios;
            idle(1);
            chk({16'h0, irq_out}, 32'hFFFA);
            wr(32'h8000090C, 32'h0);
            idle(3);
            chk({16'h0, irq_out}, 32'h0);
            $display("test interrupts done");
            wr(32'h80000908, 32'h00F0);
            idle(2);
            chk({16'h0, io_line_oe}, 32'h00F0);
            reset = 1'b1;
            idle(2);
            reset = 1'b0;
            chk({16'h0, io_line_oe}, 32'h0);
            chk({16'h0, io_line_out}, 32'h0);
            rd(32'h80000908, 32'h0);
            rd(32'h80000910, 32'h0);
            $display("test reset done");
        end
        summarize;
    end
endmodule
